// ---- logic/mhf_consts.vh ----
// constants of the modem host fifo arbiter
// Contract
// - fsk mode: tx and rx fifos 16x9
// - modulator and demodulator never both enabled
// - carrier sets carrier_present, unmasked bit interrupts
// - irq edge or level, programmable polarity
// - rx threshold event, full gives rx_full_event
// - rx data dropped while rx fifo full
// - tx data queued until modulator active
// - grant sets transmit_granted then sends data
// - tx threshold event and tx_full_event flag
// - manchester mode: 16-entry tx and rx fifos
// - rx entries carry tag bit for markers
// - encoder starts: preamble, start delimiter, data
// - preamble_count and manchester_invert in modem_setup
// - empty tx fifo ends packet with stop
// - jabber trip blocks new packets for silence period
// - zero limit disables jabber, steps 2.048ms
// - fsk characters pass straight to modulator
// - manchester link feeds fifos, rate independent
// - fsk: carrier pin high ignores tx, request
// - manchester pin: carrier, or jabber while sending
`ifndef MHF_CONSTS_VH
`define MHF_CONSTS_VH
// register addresses
`define MHF_A_CONTROL 7'h02
`define MHF_A_STATUS 7'h20
`define MHF_A_MASK 7'h21
`define MHF_A_SETUP 7'h22
`define MHF_A_TXFIFO 7'h23
`define MHF_A_RXFIFO 7'h24
`define MHF_A_THRESH 7'h25
`define MHF_A_JABBER 7'h27
// reset values
`define MHF_CONTROL_RST 16'h8042
`define MHF_MASK_RST 16'h0000
// control fields
`define MHF_C_IRQ_LEVEL 2
`define MHF_C_IRQ_POL 3
// modem_setup fields
`define MHF_S_TX_REQ 0
`define MHF_S_MANCH 8
`define MHF_S_PRE_HI 14
`define MHF_S_PRE_LO 12
`define MHF_S_INVERT 15
// modem_event_flags fields
`define MHF_E_GRANT 0
`define MHF_E_CARRIER 1
`define MHF_E_TX_FULL 3
`define MHF_E_TX_THR 4
`define MHF_E_RX_FULL 6
`define MHF_E_RX_THR 7
`define MHF_E_JABBER_TRIPPED 8
`define MHF_E_JABBER_RELEASED 9
// encoder symbols
`define MHF_SYM_PRE 9'h155
`define MHF_SYM_START 9'h14d
`define MHF_SYM_STOP 9'h126
// spi frame
`define MHF_FRAME_BITS 6'd24
// timing
`define MHF_CLK_NS 4
`define MHF_JAB_STEP_NS 2048000
`define MHF_SILENCE_US 3000000
`define MHF_CLK_MHZ 250
`endif

// ---- logic/mhf_fifo.v ----
// flip-flop fifo with level count
`timescale 1ns/10ps
`default_nettype none
module mhf_fifo #(
  parameter W = 9,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // fill side
  input wire push,
  input wire [W-1:0] din,
  // drain side
  input wire pop,
  output wire [W-1:0] dout,
  // level
  output wire [AW:0] count,
  output wire full,
  output wire empty
);
  localparam DEPTH = 1 << AW;
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire do_push;
  wire do_pop;

  // refused pushes and pops leave the contents alone
  assign full = (cnt_q == DEPTH[AW:0]);
  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign dout = mem_q[rp_q];
  assign count = cnt_q;

  // storage written by index
  always @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q] <= din;
    end
  end

  // pointers and level
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/mhf_arbiter.v ----
// modem host fifo arbiter with spi register port
`timescale 1ns/10ps
`default_nettype none
`include "mhf_consts.vh"
module mhf_arbiter #(
  parameter AW = 4,
  parameter JAB_STEP_CYC = `MHF_JAB_STEP_NS / `MHF_CLK_NS,
  parameter SILENCE_CYC = `MHF_SILENCE_US * `MHF_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // spi host port
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  // host pins
  output reg irq,
  output reg cd_pin,
  // receive stream from demodulator or decoder
  input wire rx_valid,
  input wire [8:0] rx_data,
  input wire carrier_in,
  // transmit stream to modulator or encoder
  output reg tx_valid,
  output reg [8:0] tx_data,
  input wire tx_ready,
  // path enables and encoder setting
  output reg mod_en,
  output reg demod_en,
  output reg man_invert
);
  localparam S_IDLE = 3'd0;
  localparam S_GRANT = 3'd1;
  localparam S_PRE = 3'd2;
  localparam S_SD = 3'd3;
  localparam S_DATA = 3'd4;
  localparam S_STOP = 3'd5;
  localparam S_DRAIN = 3'd6;

  // pin synchronisers
  reg [2:0] sclk_q;
  reg [1:0] cs_q;
  reg cs_d1_q;
  reg [1:0] sdi_q;
  // spi shifters
  reg [23:0] in_sh_q;
  reg [23:0] out_sh_q;
  reg [23:0] resp_q;
  reg [5:0] bits_q;
  // registers
  reg [15:0] ctrl_q;
  reg [15:0] mask_q;
  reg [15:0] setup_q;
  reg [7:0] thr_q;
  reg [7:0] jab_q;
  reg [15:0] status_q;
  // sequencer
  reg [2:0] state_q;
  reg [2:0] pre_q;
  reg jab_block_q;
  reg [31:0] step_q;
  reg [7:0] units_q;
  reg [31:0] quiet_q;
  // two-entry output buffer
  reg [8:0] buf1_q;
  reg [1:0] bcnt_q;

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_fall = ~cs_q[1] & cs_d1_q;
  wire cs_rise = cs_q[1] & ~cs_d1_q;
  wire frame_ok = cs_rise && (bits_q >= `MHF_FRAME_BITS);
  wire f_read = in_sh_q[23];
  wire [6:0] f_addr = in_sh_q[22:16];
  wire [15:0] f_data = in_sh_q[15:0];
  wire manch = setup_q[`MHF_S_MANCH];

  // fifo wiring
  wire tx_push;
  wire tx_pop;
  wire [8:0] txf_dout;
  wire [AW:0] txf_cnt;
  wire txf_full;
  wire txf_empty;
  wire rx_push;
  wire rx_pop;
  wire [8:0] rxf_dout;
  wire [AW:0] rxf_cnt;
  wire rxf_full;
  wire rxf_empty;

  // buffer handshake
  wire buf_ready = (bcnt_q != 2'd2) | tx_ready;
  wire buf_take = tx_valid & tx_ready;
  reg buf_put;
  reg [8:0] buf_in;

  // sequencer next values
  reg [2:0] state_d;
  reg [2:0] pre_d;
  reg seq_pop;
  wire jab_trip;
  wire jab_done;
  wire sending = (state_q != S_IDLE);

  // one value compared against a programmed threshold
  function at_thr;
    input [AW:0] lvl;
    input [3:0] thr;
    begin
      at_thr = (thr != 4'd0) && (lvl >= {1'b0, thr});
    end
  endfunction

  // read mux for the register port
  function [15:0] reg_read;
    input [6:0] a;
    input [15:0] c, st, m, su;
    input [7:0] th, jb;
    input [8:0] rxw;
    begin
      case (a)
        `MHF_A_CONTROL: reg_read = c;
        `MHF_A_STATUS: reg_read = st;
        `MHF_A_MASK: reg_read = m;
        `MHF_A_SETUP: reg_read = su;
        `MHF_A_RXFIFO: reg_read = {7'h00, rxw};
        `MHF_A_THRESH: reg_read = {8'h00, th};
        `MHF_A_JABBER: reg_read = {8'h00, jb};
        default: reg_read = 16'h0000;
      endcase
    end
  endfunction

  wire [15:0] rdata = reg_read(f_addr, ctrl_q, status_q, mask_q,
    setup_q, thr_q, jab_q, rxf_empty ? 9'h000 : rxf_dout);

  // host writes to tx fifo, dropped while carrier pin high
  assign tx_push = frame_ok && !f_read && (f_addr == `MHF_A_TXFIFO)
    && !cd_pin;
  assign tx_pop = seq_pop;
  // received entries stored with their tag bit, lost when full
  assign rx_push = rx_valid & demod_en & ~rxf_full;
  assign rx_pop = frame_ok && f_read && (f_addr == `MHF_A_RXFIFO);

  // transmit fifo, 16 entries of 9 bits
  mhf_fifo #(.W(9), .AW(AW)) u_txf (
    .clk(clk),
    .nrst(nrst),
    .push(tx_push),
    .din(f_data[8:0]),
    .pop(tx_pop),
    .dout(txf_dout),
    .count(txf_cnt),
    .full(txf_full),
    .empty(txf_empty)
  );

  // receive fifo, 16 entries of 9 bits
  mhf_fifo #(.W(9), .AW(AW)) u_rxf (
    .clk(clk),
    .nrst(nrst),
    .push(rx_push),
    .din(rx_data),
    .pop(rx_pop),
    .dout(rxf_dout),
    .count(rxf_cnt),
    .full(rxf_full),
    .empty(rxf_empty)
  );

  // two-flop synchronisers and edge history
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 3'h0;
      cs_q <= 2'h3;
      cs_d1_q <= 1'b1;
      sdi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q <= {cs_q[0], cs_n};
      cs_d1_q <= cs_q[1];
      sdi_q <= {sdi_q[0], sdi};
    end
  end

  // spi shift in on falling sclk, out on rising sclk
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_sh_q <= 24'h000000;
      out_sh_q <= 24'h000000;
      resp_q <= 24'h000000;
      bits_q <= 6'd0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~cs_q[1];
      if (cs_fall) begin
        out_sh_q <= resp_q;
        bits_q <= 6'd0;
      end else if (!cs_q[1] && sclk_fall) begin
        in_sh_q <= {in_sh_q[22:0], sdi_q[1]};
        if (bits_q != 6'h3f) begin
          bits_q <= bits_q + 6'd1;
        end
      end else if (!cs_q[1] && sclk_rise) begin
        sdo <= out_sh_q[23];
        out_sh_q <= {out_sh_q[22:0], 1'b0};
      end
      if (frame_ok) begin
        resp_q <= f_read ? {1'b1, f_addr, rdata} : in_sh_q;
      end
    end
  end

  // software-written registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `MHF_CONTROL_RST;
      mask_q <= `MHF_MASK_RST;
      setup_q <= 16'h0000;
      thr_q <= 8'h00;
      jab_q <= 8'h00;
    end else if (frame_ok && !f_read) begin
      case (f_addr)
        `MHF_A_CONTROL: ctrl_q <= f_data;
        `MHF_A_MASK: mask_q <= f_data;
        `MHF_A_SETUP: setup_q <= f_data;
        `MHF_A_THRESH: thr_q <= f_data[7:0];
        `MHF_A_JABBER: jab_q <= f_data[7:0];
        default: ;
      endcase
    end
  end

  // events raised this cycle
  reg [15:0] ev_set;
  always @* begin
    ev_set = 16'h0000;
    ev_set[`MHF_E_CARRIER] = carrier_in & demod_en;
    ev_set[`MHF_E_GRANT] = (state_q == S_IDLE) && (state_d == S_GRANT);
    ev_set[`MHF_E_RX_THR] = at_thr(rxf_cnt, thr_q[7:4]);
    ev_set[`MHF_E_RX_FULL] = rxf_full;
    ev_set[`MHF_E_TX_THR] = at_thr(txf_cnt, thr_q[3:0]);
    ev_set[`MHF_E_TX_FULL] = txf_full;
    ev_set[`MHF_E_JABBER_TRIPPED] = jab_trip;
    ev_set[`MHF_E_JABBER_RELEASED] = jab_done;
  end

  wire st_clr = frame_ok && f_read && (f_addr == `MHF_A_STATUS);
  wire [15:0] live = ev_set & ~mask_q;
  wire [15:0] fresh = live & ~status_q;

  // sticky flags, cleared by reading them, a new event wins
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= (st_clr ? 16'h0000 : status_q) | ev_set;
    end
  end

  // interrupt pin, level or edge, polarity selectable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b1;
    end else if (ctrl_q[`MHF_C_IRQ_LEVEL]) begin
      irq <= ~ctrl_q[`MHF_C_IRQ_POL] ^
        (|(status_q & ~mask_q & ~{16{st_clr}}));
    end else begin
      irq <= ~ctrl_q[`MHF_C_IRQ_POL] ^ (|fresh);
    end
  end

  // jabber timer counts sending time in steps
  assign jab_trip = manch && sending && !jab_block_q &&
    (jab_q != 8'h00) && (units_q == jab_q);
  assign jab_done = jab_block_q && (quiet_q == SILENCE_CYC - 1);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_q <= 32'd0;
      units_q <= 8'h00;
      quiet_q <= 32'd0;
      jab_block_q <= 1'b0;
    end else if (jab_block_q) begin
      quiet_q <= quiet_q + 32'd1;
      if (jab_done) begin
        jab_block_q <= 1'b0;
        quiet_q <= 32'd0;
      end
    end else if (jab_trip) begin
      jab_block_q <= 1'b1;
      step_q <= 32'd0;
      units_q <= 8'h00;
    end else if (manch && sending && jab_q != 8'h00) begin
      if (step_q == JAB_STEP_CYC - 1) begin
        step_q <= 32'd0;
        units_q <= units_q + 8'h01;
      end else begin
        step_q <= step_q + 32'd1;
      end
    end else begin
      step_q <= 32'd0;
      units_q <= 8'h00;
    end
  end

  // arbitration and packet framing
  always @* begin
    state_d = state_q;
    pre_d = pre_q;
    seq_pop = 1'b0;
    buf_put = 1'b0;
    buf_in = txf_dout;
    case (state_q)
      S_IDLE: begin
        if (!manch) begin
          if (setup_q[`MHF_S_TX_REQ] && !carrier_in) begin
            state_d = S_GRANT;
          end
        end else if (!txf_empty && !carrier_in && !jab_block_q) begin
          state_d = S_PRE;
          pre_d = setup_q[`MHF_S_PRE_HI:`MHF_S_PRE_LO];
        end
      end
      S_GRANT: begin
        if (!txf_empty && buf_ready) begin
          seq_pop = 1'b1;
          buf_put = 1'b1;
        end else if (!setup_q[`MHF_S_TX_REQ] && txf_empty &&
            bcnt_q == 2'd0) begin
          state_d = S_IDLE;
        end
      end
      S_PRE: begin
        buf_in = `MHF_SYM_PRE;
        if (buf_ready) begin
          buf_put = 1'b1;
          pre_d = pre_q - 3'd1;
          if (pre_q == 3'd0) begin
            state_d = S_SD;
          end
        end
      end
      S_SD: begin
        buf_in = `MHF_SYM_START;
        if (buf_ready) begin
          buf_put = 1'b1;
          state_d = S_DATA;
        end
      end
      S_DATA: begin
        if (txf_empty || jab_trip) begin
          state_d = S_STOP;
        end else if (buf_ready) begin
          seq_pop = 1'b1;
          buf_put = 1'b1;
        end
      end
      S_STOP: begin
        buf_in = `MHF_SYM_STOP;
        if (buf_ready) begin
          buf_put = 1'b1;
          state_d = S_DRAIN;
        end
      end
      // encoder stays enabled until the stop symbol is taken
      S_DRAIN: begin
        if (bcnt_q == 2'd0) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // sequencer state and path enables, never both on
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      pre_q <= 3'd0;
      mod_en <= 1'b0;
      demod_en <= 1'b1;
      man_invert <= 1'b0;
      cd_pin <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_q <= pre_d;
      mod_en <= (state_d != S_IDLE);
      demod_en <= (state_d == S_IDLE);
      man_invert <= setup_q[`MHF_S_INVERT];
      if (manch && sending) begin
        cd_pin <= jab_block_q | jab_trip;
      end else begin
        cd_pin <= carrier_in & (state_d == S_IDLE);
      end
    end
  end

  // two-entry buffer toward the modulator or encoder
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= 9'h000;
      buf1_q <= 9'h000;
      bcnt_q <= 2'd0;
    end else begin
      case ({buf_put, buf_take})
        2'b10: begin
          if (bcnt_q == 2'd0) begin
            tx_data <= buf_in;
          end else begin
            buf1_q <= buf_in;
          end
          bcnt_q <= bcnt_q + 2'd1;
          tx_valid <= 1'b1;
        end
        2'b01: begin
          tx_data <= buf1_q;
          bcnt_q <= bcnt_q - 2'd1;
          tx_valid <= (bcnt_q == 2'd2);
        end
        2'b11: begin
          if (bcnt_q == 2'd1) begin
            tx_data <= buf_in;
          end else begin
            tx_data <= buf1_q;
            buf1_q <= buf_in;
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/mhf_host_model.sv ----
// spi host model for the register port
`timescale 1ns/10ps
`default_nettype none
module mhf_host_model (
  // spi pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // idle pins at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // one 24-bit frame, msb first, data set on the rising sclk edge
  task automatic xfer(input logic [23:0] f, output logic [23:0] r);
    integer i;
    begin
      cs_n = 1'b0;
      #20;
      for (i = 23; i >= 0; i = i - 1) begin
        sclk = 1'b1;
        sdi = f[i];
        #16;
        sclk = 1'b0;
        r[i] = sdo;
        #16;
      end
      sdi = ~f[0]; // released line must not keep the last bit
      cs_n = 1'b1;
      #40;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/mhf_arbiter_chk.sv ----
// port assertions of the modem host fifo arbiter
`timescale 1ns/10ps
`default_nettype none
module mhf_arbiter_chk (
  // clock, reset, spi
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // host pins and streams
  input wire logic irq,
  input wire logic cd_pin,
  input wire logic rx_valid,
  input wire logic [8:0] rx_data,
  input wire logic carrier_in,
  input wire logic tx_valid,
  input wire logic [8:0] tx_data,
  input wire logic tx_ready,
  input wire logic mod_en,
  input wire logic demod_en,
  input wire logic man_invert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // path enables
  a_path_excl: assert property (demod_en == !mod_en)
    else $error("both paths enabled");
  a_reset_state: assert property (!$past(nrst) |-> demod_en && !tx_valid)
    else $error("wrong state after reset");
  a_mod_grant: assert property ($rose(mod_en) |-> !$past(cd_pin))
    else $error("modulator enabled under carrier");
  a_tx_gated: assert property (tx_valid && tx_ready |-> mod_en)
    else $error("word sent while modulator idle");
  // stalled words stand
  a_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("word withdrawn during stall");
  a_data_hold: assert property (tx_valid && !tx_ready |=> $stable(tx_data))
    else $error("word changed during stall");
  // spi output enable and setup updates
  a_oe_idle: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  a_oe_sel: assert property (!cs_n [*4] |-> sdo_oe)
    else $error("sdo not driven while selected");
  a_invert_hold: assert property ($changed(man_invert) |-> cs_n)
    else $error("invert changed inside a frame");
  c_grant: cover property ($rose(mod_en));
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_ready);
  c_frame: cover property ($fell(cs_n));
endmodule
bind mhf_arbiter mhf_arbiter_chk i_chk (.clk(clk), .nrst(nrst),
  .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .irq(irq), .cd_pin(cd_pin), .rx_valid(rx_valid), .rx_data(rx_data),
  .carrier_in(carrier_in), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .mod_en(mod_en), .demod_en(demod_en),
  .man_invert(man_invert));
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the modem host fifo arbiter
`timescale 1ns/10ps
`default_nettype none
`include "mhf_consts.vh"
module testbench;
  logic clk, nrst, rx_valid, carrier_in, tx_ready, en_rdy;
  logic [8:0] rx_data;
  logic [15:0] d;
  logic [23:0] r;
  logic [8:0] q[$];
  logic [8:0] got[$];
  wire sclk, cs_n, sdi, sdo, sdo_oe, irq, cd_pin;
  wire tx_valid, mod_en, demod_en, man_invert;
  wire [8:0] tx_data;
  integer err_total = 0;
  integer n_checks = 0;
  integer seed = 73406;
  integer i;
  // design with short jabber counts
  mhf_arbiter #(.JAB_STEP_CYC(8), .SILENCE_CYC(20)) i_dut (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq), .cd_pin(cd_pin),
    .rx_valid(rx_valid), .rx_data(rx_data), .carrier_in(carrier_in),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .mod_en(mod_en), .demod_en(demod_en), .man_invert(man_invert));
  mhf_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // stalling receiver, collects taken words
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= #1 en_rdy & 1'($random(seed));
  end
  // compare tasks
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] a);
    n_checks = n_checks + 1;
    if (a !== e) begin
      err_total = err_total + 1;
      $display("[ERR] %s exp %h got %h", nm, e, a);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic a);
    chk(nm, {15'h0, e}, {15'h0, a});
  endtask
  task automatic cmp_got;
    chk("words", 16'(q.size()), 16'(got.size()));
    for (int k = 0; k < q.size() && k < got.size(); k++)
      chk("word", {7'h0, q[k]}, {7'h0, got[k]});
  endtask
  // clock steps and register access
  task automatic cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    i_host.xfer({1'b0, a, v}, r);
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    i_host.xfer({1'b1, a, 16'h0}, r);
    i_host.xfer({1'b1, 7'h7f, 16'h0}, r);
    v = r[15:0];
    cyc(1);
  endtask
  task automatic wait_got(input integer n);
    for (int k = 0; k < 3000 && got.size() < n; k++) cyc(1);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    err_total = err_total + 1;
    complete_run();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    {rx_valid, carrier_in, tx_ready, en_rdy} = 4'h0;
    rx_data = 9'h000;
    cyc(10);
    nrst = 1'b1;
    cyc(4);
    chk1("demod_en", 1'b1, demod_en);
    chk1("irq idle", 1'b1, irq);
    rd(`MHF_A_CONTROL, d);
    chk("control", 16'h8042, d);
    rd(`MHF_A_MASK, d);
    chk("mask", 16'h0000, d);
    rd(7'h7f, d);
    chk("unmapped", 16'h0000, d);
    // rx burst past full, irq masked, level mode active high
    wr(`MHF_A_CONTROL, 16'h804e);
    wr(`MHF_A_MASK, 16'hffff);
    wr(`MHF_A_THRESH, 16'h0050);
    carrier_in = 1'b1;
    for (i = 0; i < 17; i = i + 1) begin
      rx_data = 9'($random(seed));
      rx_valid = 1'b1;
      if (i < 16) q.push_back(rx_data);
      cyc(1);
    end
    rx_valid = 1'b0;
    cyc(4);
    chk1("irq masked", 1'b0, irq);
    chk1("cd_pin", 1'b1, cd_pin);
    carrier_in = 1'b0;
    rd(`MHF_A_STATUS, d);
    chk("rx flags", 16'h00c2, d & 16'h00c2);
    wr(`MHF_A_MASK, 16'h0000);
    chk1("irq level", 1'b1, irq);
    for (i = 0; i < 16; i = i + 1) begin
      rd(`MHF_A_RXFIFO, d);
      chk("rx word", {7'h0, q[i]}, d);
    end
    rd(`MHF_A_RXFIFO, d);
    chk("rx empty", 16'h0000, d);
    rd(`MHF_A_STATUS, d);
    rd(`MHF_A_STATUS, d);
    chk1("irq cleared", 1'b0, irq);
    // request and fifo data refused under carrier
    q.delete();
    carrier_in = 1'b1;
    wr(`MHF_A_SETUP, 16'h0001);
    wr(`MHF_A_TXFIFO, 16'h01aa);
    chk1("mod_en held", 1'b0, mod_en);
    wr(`MHF_A_SETUP, 16'h0000);
    carrier_in = 1'b0;
    wr(`MHF_A_THRESH, 16'h0003);
    for (i = 0; i < 17; i = i + 1) begin
      d = 16'($random(seed)) & 16'h01ff;
      wr(`MHF_A_TXFIFO, d);
      if (i < 16) q.push_back(d[8:0]);
    end
    rd(`MHF_A_STATUS, d);
    chk("tx flags", 16'h0018, d & 16'h0019);
    en_rdy = 1'b1;
    wr(`MHF_A_SETUP, 16'h0001);
    wait_got(16);
    chk1("mod_en", 1'b1, mod_en);
    cmp_got();
    rd(`MHF_A_STATUS, d);
    chk("grant", 16'h0001, d & 16'h0001);
    wr(`MHF_A_SETUP, 16'h0000);
    // encoder packet built while the receiver stalls
    q = '{`MHF_SYM_PRE, `MHF_SYM_PRE, `MHF_SYM_PRE, `MHF_SYM_START};
    got.delete();
    en_rdy = 1'b0;
    wr(`MHF_A_JABBER, 16'h0000);
    wr(`MHF_A_SETUP, 16'ha100);
    chk1("invert", 1'b1, man_invert);
    for (i = 0; i < 3; i = i + 1) begin
      d = {8'h00, 8'($random(seed))};
      wr(`MHF_A_TXFIFO, d);
      q.push_back(d[8:0]);
    end
    q.push_back(`MHF_SYM_STOP);
    en_rdy = 1'b1;
    wait_got(8);
    cmp_got();
    // jabber trip on a stalled packet
    rd(`MHF_A_STATUS, d);
    chk("no jabber", 16'h0000, d & 16'h0300);
    wr(`MHF_A_JABBER, 16'h0001);
    rd(`MHF_A_JABBER, d);
    chk("jabber limit", 16'h0001, d);
    en_rdy = 1'b0;
    wr(`MHF_A_TXFIFO, 16'h0033);
    rd(`MHF_A_STATUS, d);
    chk("jabber flags", 16'h0300, d & 16'h0300);
    en_rdy = 1'b1;
    cyc(50);
    complete_run();
  end
endmodule
`default_nettype wire
